//--- hw/pfg_pkg.sv
// Constants and types shared by the frame generator/checker block
package pfg_pkg;
    // ==========================================
    // Register indexes, byte address is 4x index
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_CTRL = 16'h40a0;
    localparam logic [15:0] IDX_LEN = 16'h40a1;
    localparam logic [15:0] IDX_BURST = 16'h40a2;
    localparam logic [15:0] IDX_RXH = 16'h40a3;
    localparam logic [15:0] IDX_RXL = 16'h40a4;
    // ==========================================
    // Control fields and reset values
    localparam int CHK_EN_BIT = 15;
    localparam int GATE_BIT = 14;
    localparam int BYPASS_BIT = 13;
    localparam int RUN_BIT = 12;
    localparam int PRE_LO = 8;
    localparam int GAP_LO = 4;
    localparam int FORCE_BIT = 3;
    localparam int CORRUPT_BIT = 2;
    localparam int KIND_LO = 0;
    localparam logic [15:0] CTRL_RST = 16'h68d0;
    localparam logic [15:0] LEN_RST = 16'h0040;
    localparam logic [15:0] BURST_RST = 16'h0000;
    localparam logic [3:0] PRE_RST = 4'h8;
    localparam logic [3:0] GAP_RST = 4'hd;
    localparam logic [3:0] MIN_FIELD = 4'h2;
    // ==========================================
    // Frame content
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hd5;
    localparam logic [31:0] FIX_WORD = 32'h5aa55aa5;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
    localparam logic [15:0] FCS_BYTES = 16'h0004;
    localparam logic [15:0] MIN_FRAME = 16'd64;
    localparam logic [15:0] MAX_FRAME = 16'd1518;
    localparam logic [7:0] LFSR_SEED = 8'h01;
    localparam logic [1:0] KIND_INC = 2'b00;
    localparam logic [1:0] KIND_RAND = 2'b01;
    localparam logic [1:0] KIND_FIX = 2'b10;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    typedef enum logic [2:0] {
        G_IDLE, G_PRE, G_SFD, G_DATA, G_FCS, G_GAP
    } pfg_gen_st_t;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] d;
    } pfg_mii_t;
endpackage

//--- hw/pfg_top.sv
// Self-test frame generator, path select and good-frame checkers
`timescale 1ns/1ps
`default_nettype none
module pfg_top
    import pfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pfg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pfg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pfg_pkg::pfg_mii_t mac_tx,
    input wire pfg_pkg::pfg_mii_t phy_rx,
    input wire logic link_up,
    output pfg_pkg::pfg_mii_t phy_tx,
    output logic selftest_clk_on,
    output logic [31:0] tx_good_frame_total
);
    import pfg_pkg::*;

    function automatic logic [31:0] crc4(input logic [31:0] c,
                                         input logic [3:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++)
            r = (r >> 1) ^ ((r[0] ^ d[i]) ? CRC_POLY : 32'h0);
        return r;
    endfunction

    // ==========================================
    // State
    logic [15:0] ctrl_q, ctrl_d, len_q, len_d, burst_q, burst_d;
    logic [3:0] pre_q, pre_d, gap_q, gap_d;
    pfg_mii_t mac_s1_q, mac_s2_q, tx_q, tx_d;
    pfg_gen_st_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d, sent_q, sent_d;
    logic nib_q, nib_d;
    logic [31:0] crc_q, crc_d;
    logic [7:0] lfsr_q, lfsr_d;
    logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
    logic [ADDR_W-1:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0] ws_q, ws_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    // Checker index 0 is receive, 1 is transmit
    logic [1:0] c_prev_q, c_prev_d, c_sfd_q, c_sfd_d, c_nib_q, c_nib_d;
    logic [31:0] c_crc_q[2], c_crc_d[2], tot_q[2], tot_d[2];
    logic [15:0] c_len_q[2], c_len_d[2];
    pfg_mii_t chk_in[2];

    // ==========================================
    // Next-state logic
    logic run, bypass, chk_en, on, gen_en, byte_end, wr_go, rd_go;
    logic [7:0] cur;
    logic [15:0] dlen, windex, rindex;
    logic [31:0] c_nx, g_nx;

    always_comb
    begin
        run = ctrl_q[RUN_BIT];
        bypass = ctrl_q[BYPASS_BIT];
        chk_en = ctrl_q[CHK_EN_BIT];
        on = !(ctrl_q[GATE_BIT] && !chk_en && bypass && !run);
        dlen = (len_q > FCS_BYTES) ? len_q - FCS_BYTES : 16'h0;
        byte_end = nib_q;
        chk_in[0] = phy_rx;
        chk_in[1] = tx_q;
        ctrl_d = ctrl_q;
        len_d = len_q;
        burst_d = burst_q;
        pre_d = pre_q;
        gap_d = gap_q;
        st_d = st_q;
        cnt_d = cnt_q;
        sent_d = sent_q;
        nib_d = on ? !nib_q : 1'b0;
        crc_d = crc_q;
        lfsr_d = lfsr_q;
        unique case (ctrl_q[KIND_LO +: 2])
            KIND_INC: cur = cnt_q[7:0];
            KIND_RAND: cur = lfsr_q;
            KIND_FIX: cur = FIX_WORD[8 * (3 - cnt_q[1:0]) +: 8];
            default: cur = 8'h00;
        endcase
        if (st_q == G_PRE)
            cur = PRE_BYTE;
        else if (st_q == G_SFD)
            cur = SFD_BYTE;
        else if (st_q == G_FCS)
            // Check word shifts a nibble per clock, so both halves
            // come from its lowest nibble
            cur = {crc_q[3:0], crc_q[3:0]};
        g_nx = crc4(crc_q, nib_q ? cur[7:4] : cur[3:0]);
        gen_en = st_q inside {G_PRE, G_SFD, G_DATA, G_FCS};
        // Generator walks one nibble per clock; forced back to G_IDLE while gated
        if (!on)
            st_d = G_IDLE;
        else
        begin
            unique case (st_q)
                G_IDLE:
                begin
                    nib_d = 1'b0;
                    cnt_d = 16'h0;
                    if (!run)
                        sent_d = 16'h0;
                    else if (link_up || ctrl_q[FORCE_BIT])
                        st_d = G_PRE;
                end
                G_PRE:
                    if (byte_end)
                    begin
                        cnt_d = cnt_q + 16'h1;
                        if (cnt_q == {12'h0, pre_q} - 16'h1)
                            st_d = G_SFD;
                    end
                G_SFD:
                    if (byte_end)
                    begin
                        cnt_d = 16'h0;
                        crc_d = CRC_INIT;
                        st_d = (dlen == 16'h0) ? G_FCS : G_DATA;
                        if (dlen == 16'h0)
                            crc_d = ~CRC_INIT ^
                                {31'h0, ctrl_q[CORRUPT_BIT]};
                    end
                G_DATA:
                begin
                    crc_d = g_nx;
                    if (byte_end)
                    begin
                        cnt_d = cnt_q + 16'h1;
                        lfsr_d = {lfsr_q[6:0],
                            lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
                        if (cnt_q == dlen - 16'h1)
                        begin
                            st_d = G_FCS;
                            cnt_d = 16'h0;
                            crc_d = ~g_nx ^
                                {31'h0, ctrl_q[CORRUPT_BIT]};
                        end
                    end
                end
                G_FCS:
                begin
                    crc_d = crc_q >> 4;
                    if (byte_end)
                    begin
                        cnt_d = cnt_q + 16'h1;
                        if (cnt_q == FCS_BYTES - 16'h1)
                        begin
                            st_d = G_GAP;
                            cnt_d = 16'h0;
                            sent_d = sent_q + 16'h1;
                            if (burst_q != 16'h0 &&
                                sent_q + 16'h1 >= burst_q)
                            begin
                                ctrl_d[RUN_BIT] = 1'b0;
                                sent_d = 16'h0;
                            end
                        end
                    end
                end
                G_GAP:
                    if (byte_end)
                    begin
                        cnt_d = cnt_q + 16'h1;
                        if (cnt_q == {12'h0, gap_q} - 16'h1)
                            st_d = G_IDLE;
                    end
            endcase
        end
        // Path select feeds the transmitter
        if (bypass)
            tx_d = mac_s2_q;
        else
        begin
            tx_d.en = gen_en;
            tx_d.er = 1'b0;
            tx_d.d = nib_q ? cur[7:4] : cur[3:0];
        end
        // Checkers; a frame is judged on the fall of its enable
        c_prev_d = c_prev_q;
        c_sfd_d = c_sfd_q;
        c_nib_d = c_nib_q;
        for (int k = 0; k < 2; k++)
        begin
            c_crc_d[k] = c_crc_q[k];
            c_len_d[k] = c_len_q[k];
            tot_d[k] = tot_q[k];
            c_nx = crc4(c_crc_q[k], chk_in[k].d);
            c_prev_d[k] = chk_in[k].en && chk_en && on;
            if (!(chk_en && on))
            begin
                c_sfd_d[k] = 1'b0;
                c_nib_d[k] = 1'b0;
            end
            else if (chk_in[k].en)
            begin
                if (!c_sfd_q[k])
                begin
                    c_sfd_d[k] = (chk_in[k].d == SFD_BYTE[7:4]) &&
                        c_prev_q[k];
                    c_crc_d[k] = CRC_INIT;
                    c_len_d[k] = 16'h0;
                    c_nib_d[k] = 1'b0;
                end
                else
                begin
                    c_crc_d[k] = c_nx;
                    c_nib_d[k] = !c_nib_q[k];
                    if (c_nib_q[k] && c_len_q[k] != 16'hffff)
                        c_len_d[k] = c_len_q[k] + 16'h1;
                end
            end
            else
            begin
                c_sfd_d[k] = 1'b0;
                if (c_sfd_q[k] && c_crc_q[k] == CRC_RESIDUE &&
                    c_len_q[k] >= MIN_FRAME && c_len_q[k] <= MAX_FRAME)
                    tot_d[k] = tot_q[k] + 32'h1;
            end
        end
        tx_good_frame_total = tot_q[1];
        // AXI4-Lite slave
        aw_d = aw_q || s_axi_awvalid;
        awa_d = aw_q ? awa_q : s_axi_awaddr;
        w_d = w_q || s_axi_wvalid;
        wd_d = w_q ? wd_q : s_axi_wdata;
        ws_d = w_q ? ws_q : s_axi_wstrb;
        b_d = b_q && !s_axi_bready;
        bresp_d = bresp_q;
        r_d = r_q && !s_axi_rready;
        rd_d = rd_q;
        rresp_d = rresp_q;
        windex = 16'(awa_q >> 2);
        rindex = 16'(s_axi_araddr >> 2);
        wr_go = aw_q && w_q && !b_q;
        rd_go = s_axi_arvalid && !r_q;
        if (wr_go)
        begin
            aw_d = 1'b0;
            w_d = 1'b0;
            b_d = 1'b1;
            bresp_d = RESP_OK;
            for (int i = 0; i < 2; i++)
                if (ws_q[i])
                    unique case (windex)
                        IDX_CTRL: ctrl_d[8*i +: 8] = wd_q[8*i +: 8];
                        IDX_LEN: len_d[8*i +: 8] = wd_q[8*i +: 8];
                        IDX_BURST: burst_d[8*i +: 8] = wd_q[8*i +: 8];
                        IDX_RXH, IDX_RXL: ;
                        default: bresp_d = RESP_ERR;
                    endcase
            if (!(windex inside {IDX_CTRL, IDX_LEN, IDX_BURST, IDX_RXH,
                                 IDX_RXL}))
                bresp_d = RESP_ERR;
            // Short fields keep their last usable value
            if (windex == IDX_CTRL && ws_q[1] &&
                wd_q[PRE_LO +: 4] >= MIN_FIELD)
                pre_d = wd_q[PRE_LO +: 4];
            if (windex == IDX_CTRL && ws_q[0] &&
                wd_q[GAP_LO +: 4] >= MIN_FIELD)
                gap_d = wd_q[GAP_LO +: 4];
        end
        if (rd_go)
        begin
            r_d = 1'b1;
            rresp_d = RESP_OK;
            // Clear-on-read; a frame counted this cycle survives
            unique case (rindex)
                IDX_CTRL: rd_d = {16'h0, ctrl_q};
                IDX_LEN: rd_d = {16'h0, len_q};
                IDX_BURST: rd_d = {16'h0, burst_q};
                IDX_RXH:
                begin
                    rd_d = {16'h0, tot_q[0][31:16]};
                    tot_d[0] = {16'h0, tot_q[0][15:0]} +
                        (tot_d[0] - tot_q[0]);
                end
                IDX_RXL:
                begin
                    rd_d = {16'h0, tot_q[0][15:0]};
                    tot_d[0] = {tot_q[0][31:16], 16'h0} +
                        (tot_d[0] - tot_q[0]);
                end
                default:
                begin
                    rd_d = 32'h0;
                    rresp_d = RESP_ERR;
                end
            endcase
        end
        s_axi_awready = !aw_q;
        s_axi_wready = !w_q;
        s_axi_bvalid = b_q;
        s_axi_bresp = bresp_q;
        s_axi_arready = !r_q;
        s_axi_rvalid = r_q;
        s_axi_rdata = rd_q;
        s_axi_rresp = rresp_q;
        phy_tx = tx_q;
        selftest_clk_on = on;
    end

    // ==========================================
    // Registers
    always_ff @(posedge aclk)
    begin
        // MAC pins are outside this clock, so two stages first
        mac_s1_q <= mac_tx;
        mac_s2_q <= mac_s1_q;
        if (!aresetn)
        begin
            ctrl_q <= CTRL_RST;
            len_q <= LEN_RST;
            burst_q <= BURST_RST;
            pre_q <= PRE_RST;
            gap_q <= GAP_RST;
            tx_q <= '0;
            st_q <= G_IDLE;
            cnt_q <= 16'h0;
            sent_q <= 16'h0;
            nib_q <= 1'b0;
            crc_q <= CRC_INIT;
            lfsr_q <= LFSR_SEED;
            {aw_q, w_q, b_q, r_q} <= 4'h0;
            awa_q <= '0;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            rd_q <= 32'h0;
            bresp_q <= RESP_OK;
            rresp_q <= RESP_OK;
            c_prev_q <= 2'b00;
            c_sfd_q <= 2'b00;
            c_nib_q <= 2'b00;
            for (int k = 0; k < 2; k++)
            begin
                c_crc_q[k] <= CRC_INIT;
                c_len_q[k] <= 16'h0;
                tot_q[k] <= 32'h0;
            end
        end
        else
        begin
            ctrl_q <= ctrl_d;
            len_q <= len_d;
            burst_q <= burst_d;
            pre_q <= pre_d;
            gap_q <= gap_d;
            tx_q <= tx_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            sent_q <= sent_d;
            nib_q <= nib_d;
            crc_q <= crc_d;
            lfsr_q <= lfsr_d;
            {aw_q, w_q, b_q, r_q} <= {aw_d, w_d, b_d, r_d};
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            rd_q <= rd_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            c_prev_q <= c_prev_d;
            c_sfd_q <= c_sfd_d;
            c_nib_q <= c_nib_d;
            c_crc_q <= c_crc_d;
            c_len_q <= c_len_d;
            tot_q <= tot_d;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_gate;
        ctrl_q[GATE_BIT] && !chk_en && bypass && !run |-> !selftest_clk_on
            ##1 st_q == G_IDLE && c_sfd_q == 2'b00;
    endproperty
    a_gate: assert property (p_gate) else $error("gate missed");
    property p_bypass;
        bypass |=> phy_tx == $past(mac_s2_q);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass bad");
    property p_gen_path;
        !bypass && $past(!bypass) |-> phy_tx.en == $past(gen_en);
    endproperty
    a_gen_path: assert property (p_gen_path) else $error("gen path");
    property p_nolink;
        st_q == G_IDLE && !link_up && !ctrl_q[FORCE_BIT] |=> st_q == G_IDLE;
    endproperty
    a_nolink: assert property (p_nolink) else $error("sent no link");
    property p_pre_min;
        pre_q >= MIN_FIELD && gap_q >= MIN_FIELD;
    endproperty
    a_pre_min: assert property (p_pre_min) else $error("short field");
    property p_sfd;
        st_q == G_PRE && byte_end && cnt_q == {12'h0, pre_q} - 16'h1 && on
            |=> st_q == G_SFD ##2 st_q != G_SFD;
    endproperty
    a_sfd: assert property (p_sfd) else $error("sfd timing");
    property p_chk_off;
        !chk_en |=> $stable(tot_q[1]);
    endproperty
    a_chk_off: assert property (p_chk_off) else $error("chk off");
    property p_burst_stop;
        st_q == G_FCS && byte_end && cnt_q == FCS_BYTES - 16'h1 &&
            burst_q == 16'h1 && on && !wr_go |=> !run && st_q == G_GAP;
    endproperty
    a_burst_stop: assert property (p_burst_stop) else $error("burst");
    property p_cont;
        burst_q == 16'h0 && !wr_go |=> !$fell(run);
    endproperty
    a_cont: assert property (p_cont) else $error("cont stop");
endmodule
`default_nettype wire

//--- sim/pfg_mac_model.sv
// Far-end model: MAC transmit source and receive loopback
`timescale 1ns/1ps
`default_nettype none
module pfg_mac_model
    import pfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic send_go,
    input wire pfg_pkg::pfg_mii_t phy_tx,
    output pfg_pkg::pfg_mii_t mac_tx,
    output pfg_pkg::pfg_mii_t phy_rx
);
    logic [5:0] cnt_q;
    logic [3:0] junk_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= 6'h00;
            junk_q <= 4'h3;
        end
        else
        begin
            junk_q <= junk_q + 4'h7;
            if (send_go)
                cnt_q <= 6'h28;
            else if (cnt_q != 6'h00)
                cnt_q <= cnt_q - 6'h01;
        end
    end
    // Idle data toggles so a stale nibble cannot pass for data
    always_comb
    begin
        mac_tx.en = (cnt_q != 6'h00);
        mac_tx.er = 1'b0;
        mac_tx.d = mac_tx.en ? cnt_q[3:0] : junk_q;
        phy_rx = phy_tx;
        if (!phy_tx.en)
            phy_rx.d = junk_q;
    end
endmodule
`default_nettype wire

//--- sim/pfg_top_test.sv
// Self-checking bench for the frame generator and checker block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
    begin \
        total_checks++; \
        if ((a) !== (e)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
        end \
    end
module pfg_top_test;
    import pfg_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = '0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [ADDR_W-1:0] araddr = '0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic link_up = 1'b0;
    logic send_go = 1'b0;
    logic clk_on;
    logic seen;
    logic [31:0] tx_total;
    logic [31:0] rv;
    logic [1:0] rs;
    pfg_mii_t mac_tx, phy_rx, phy_tx, d1, d2, d3;
    logic [7:0] fr[$];
    int gapn;
    int num_errors = 0;
    int total_checks = 0;
    pfg_top i_pfg_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mac_tx(mac_tx),
        .phy_rx(phy_rx), .link_up(link_up), .phy_tx(phy_tx),
        .selftest_clk_on(clk_on), .tx_good_frame_total(tx_total));
    pfg_mac_model i_pfg_mac_model (.aclk(aclk), .aresetn(aresetn),
        .send_go(send_go), .phy_tx(phy_tx), .mac_tx(mac_tx),
        .phy_rx(phy_rx));
    // Bypass path is three flops deep
    always_ff @(posedge aclk)
    begin
        d1 <= mac_tx;
        d2 <= d1;
        d3 <= d2;
    end
    // ==========================================
    // Closing and bus tasks
    task automatic wrap_up();
        begin
            $display("checks=%0d errors=%0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task automatic hang();
        begin
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] v);
        int n;
        begin
            @(posedge aclk);
            awaddr <= {idx, 2'b00};
            wdata <= {16'h0000, v};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                rs = bresp;
                if (bvalid) break;
            end
            bready <= 1'b0;
            if (n == 50) hang();
        end
    endtask
    task automatic rd(input logic [15:0] idx);
        int n;
        begin
            @(posedge aclk);
            araddr <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
                rv = rdata;
                rs = rresp;
                if (rvalid) break;
            end
            rready <= 1'b0;
            if (n == 50) hang();
        end
    endtask
    task automatic rchk(input logic [15:0] idx, input logic [31:0] e);
        begin
            rd(idx);
            `CHK(rv, e)
        end
    endtask
    // ==========================================
    // Line helpers
    task automatic quiet(input int n);
        begin
            seen = 1'b0;
            repeat (n)
            begin
                @(posedge aclk);
                if (phy_tx.en !== 1'b0) seen = 1'b1;
            end
        end
    endtask
    task automatic grab();
        logic [3:0] lo;
        logic h;
        begin
            fr = {};
            h = 1'b0;
            gapn = 0;
            while (phy_tx.en !== 1'b1 && gapn < 3000)
            begin
                @(posedge aclk);
                gapn++;
            end
            if (gapn == 3000) hang();
            while (phy_tx.en === 1'b1 && fr.size() < 2000)
            begin
                if (h) fr.push_back({phy_tx.d, lo});
                lo = phy_tx.d;
                h = !h;
                @(posedge aclk);
            end
        end
    endtask
    function automatic logic [31:0] crc_of(input int s);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = s; i < fr.size(); i++)
        begin
            c = c ^ {24'h000000, fr[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
    task automatic fchk(input int p, input int len, input logic good);
        logic ok;
        begin
            ok = 1'b1;
            for (int i = 0; i < p; i++)
                if (fr[i] !== PRE_BYTE) ok = 1'b0;
            `CHK(ok, 1'b1)
            `CHK(fr[p], SFD_BYTE)
            `CHK(fr.size(), p + 1 + len)
            `CHK(crc_of(p + 1) === CRC_RESIDUE, good)
        end
    endtask
    task automatic pulse();
        begin
            @(posedge aclk);
            send_go <= 1'b1;
            @(posedge aclk);
            send_go <= 1'b0;
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        begin
            rchk(IDX_CTRL, 32'h000068d0);
            rchk(IDX_LEN, 32'h00000040);
            rchk(IDX_BURST, 32'h00000000);
            rchk(IDX_RXH, 32'h00000000);
            rchk(IDX_RXL, 32'h00000000);
            `CHK(clk_on, 1'b0)
            rd(16'h40b3);
            `CHK(rs, RESP_ERR)
            wr(16'h40b3, 16'hffff);
            `CHK(rs, RESP_ERR)
        end
    endtask
    task automatic t_gate();
        begin
            wr(IDX_CTRL, 16'h28d0);
            `CHK(clk_on, 1'b1)
            wr(IDX_CTRL, 16'he8d0);
            `CHK(clk_on, 1'b1)
            wr(IDX_CTRL, 16'h48d0);
            `CHK(clk_on, 1'b1)
            wr(IDX_CTRL, 16'h68d0);
            `CHK(clk_on, 1'b0)
        end
    endtask
    task automatic t_bypass();
        begin
            wr(IDX_CTRL, 16'h28d0);
            pulse();
            repeat (50)
            begin
                @(posedge aclk);
                `CHK(phy_tx, d3)
            end
            wr(IDX_CTRL, 16'h08d0);
            pulse();
            quiet(50);
            `CHK(seen, 1'b0)
        end
    endtask
    task automatic t_burst();
        logic ok;
        begin
            wr(IDX_BURST, 16'h0002);
            wr(IDX_CTRL, 16'hd328);
            grab();
            fchk(3, 64, 1'b1);
            ok = 1'b1;
            for (int i = 0; i < 60; i++)
                if (fr[4 + i] !== 8'(i)) ok = 1'b0;
            `CHK(ok, 1'b1)
            grab();
            `CHK(gapn >= 4, 1'b1)
            fchk(3, 64, 1'b1);
            quiet(200);
            `CHK(seen, 1'b0)
            rchk(IDX_CTRL, 32'h0000c328);
            `CHK(tx_total, 32'h00000002)
            rchk(IDX_RXH, 32'h00000000);
            rchk(IDX_RXL, 32'h00000002);
            rchk(IDX_RXL, 32'h00000000);
        end
    endtask
    task automatic t_kinds();
        begin
            wr(IDX_BURST, 16'h0001);
            wr(IDX_LEN, 16'h003f);
            wr(IDX_CTRL, 16'hd109);
            grab();
            fchk(3, 63, 1'b1);
            quiet(100);
            wr(IDX_LEN, 16'h0040);
            wr(IDX_CTRL, 16'hd10b);
            grab();
            fchk(3, 64, 1'b1);
            `CHK(fr[4] | fr[40], 8'h00)
            quiet(100);
            wr(IDX_CTRL, 16'hd10e);
            grab();
            fchk(3, 64, 1'b0);
            `CHK(fr[4] ^ fr[5], 8'hff)
            `CHK(fr[4] == 8'h5a || fr[4] == 8'ha5, 1'b1)
            quiet(100);
            `CHK(tx_total, 32'h00000003)
            rchk(IDX_RXL, 32'h00000001);
        end
    endtask
    task automatic t_link();
        begin
            wr(IDX_CTRL, 16'h5120);
            quiet(300);
            `CHK(seen, 1'b0)
            link_up <= 1'b1;
            grab();
            fchk(3, 64, 1'b1);
            quiet(20);
            `CHK(tx_total, 32'h00000003)
            rchk(IDX_RXL, 32'h00000000);
        end
    endtask
    task automatic t_cont();
        begin
            wr(IDX_BURST, 16'h0000);
            wr(IDX_CTRL, 16'hd128);
            repeat (3) grab();
            rchk(IDX_CTRL, 32'h0000d128);
            wr(IDX_CTRL, 16'hc128);
            repeat (300) @(posedge aclk);
            quiet(200);
            `CHK(seen, 1'b0)
        end
    endtask
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    initial
    begin
        repeat (100000) @(posedge aclk);
        hang();
    end
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_gate();
        t_bypass();
        t_burst();
        t_kinds();
        t_link();
        t_cont();
        wrap_up();
    end
endmodule
`default_nettype wire
